// File: hw/cslp_pkg.sv
// constants, types and state codes for the processor state and low-power block
// Functional notes
// - stop halts oscillator, only timebase/watchdog on low_freq_crystal_clock
// - stop clears mask, all else unchanged
// - stop exits on irq, key, spi-slave, low_freq_crystal_clock tick, reset
// - wait halts cpu and bus, timers keep running
// - wait clears mask, all else unchanged
// - wait exits on enabled tick, irq, or reset
// - watchdog active when enabled; stalls in stop unless on low_freq_crystal_clock
// - enabled watchdog timeout resets the device
// - only thirteen address bits used; memory mirrors
// - accumulator holds results, survives reset
// - indexed address: index plus offset, zero high byte
// - index register temporary storage, survives reset
// - stack pointer reloads top, push decrements, pull increments
// - stack confined to 64 locations, wraps around
// - call pushes two bytes, interrupt pushes five
// - program counter increments or loads jump target
// - five flag bits, upper three read one, reset only mask
// - half carry from bit three into four on adds
// - mask set after stacking, before vector fetch
// - masked requests stay pending; return restores mask
// - reset sets mask; cleared by clear, stop, wait, or return
// - negative copies bit seven; zero on zero result
// - carry from bit seven, shifts, bit tests; not inc/dec
package cslp_pkg;

  localparam int unsigned ADDR_W      = 13;
  localparam int unsigned SP_W        = 6;
  localparam logic [ADDR_W-1:0] SP_BASE = 13'h00_C0;
  localparam logic [SP_W-1:0]   SP_TOP  = 6'h3_F;
  localparam logic [2:0] CCR_ONES     = 3'h7;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;
  localparam int unsigned HC_BIT      = 4;
  localparam int unsigned SIGN_BIT    = 7;
  localparam logic [2:0] CALL_BYTES   = 3'h2;
  localparam logic [2:0] INT_BYTES    = 3'h5;

  // stacked byte order for interrupt entry, index 0 pushed first
  localparam logic [2:0] SLOT_PCL = 3'h0;
  localparam logic [2:0] SLOT_PCH = 3'h1;
  localparam logic [2:0] SLOT_X   = 3'h2;
  localparam logic [2:0] SLOT_A   = 3'h3;
  localparam logic [2:0] SLOT_CCR = 3'h4;

  localparam int unsigned NSRC = 4;
  localparam int unsigned SRC_TICK = 0;
  localparam int unsigned SRC_SPI  = 1;
  localparam int unsigned SRC_KEY  = 2;
  localparam int unsigned SRC_IRQ  = 3;

  typedef enum logic [1:0] {
    CSLP_IDX_NONE = 2'h0,
    CSLP_IDX_OFF8 = 2'h1,
    CSLP_IDX_OFF16 = 2'h2
  } cslp_idx_t;

  typedef enum logic [5:0] {
    CSLP_RUN     = 6'h01,
    CSLP_STACK   = 6'h02,
    CSLP_VECT    = 6'h04,
    CSLP_UNSTACK = 6'h08,
    CSLP_WAIT    = 6'h10,
    CSLP_STOP    = 6'h20
  } cslp_state_t;

  typedef enum logic [1:0] {
    CSLP_SEQ_CALL = 2'h0,
    CSLP_SEQ_INT  = 2'h1,
    CSLP_SEQ_RTS  = 2'h2,
    CSLP_SEQ_RTI  = 2'h3
  } cslp_seq_t;

  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } cslp_flags_t;

  typedef struct packed {
    logic       acc_we;
    logic       x_we;
    logic       nz_we;
    logic       c_we;
    logic       c_val;
    logic       add;
    logic       adc;
    logic [7:0] data;
  } cslp_op_t;

  typedef struct packed {
    logic osc_en;
    logic cpu_clk_en;
    logic bus_en;
    logic timer_clk_en;
    logic wdog_count_en;
  } cslp_pwr_t;

endpackage

// File: hw/cslp_sync3.sv
// three-stage synchroniser for asynchronous wake and watchdog lines
`timescale 1ns/1ps
module cslp_sync3 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         resetn_i,
  // asynchronous in, filtered out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;

  // a change is taken only once the second and third stages agree
  for (genvar g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        s1_q[g]  <= 1'b0;
        s2_q[g]  <= 1'b0;
        s3_q[g]  <= 1'b0;
        out_q[g] <= 1'b0;
      end else begin
        s1_q[g] <= async_i[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
        if (s2_q[g] == s3_q[g]) begin
          out_q[g] <= s3_q[g];
        end
      end
    end
  end

  assign sync_o = out_q;

endmodule

// File: hw/cslp_core_state.sv
// programmer registers, stacking sequencer and stop/wait control
`timescale 1ns/1ps
module cslp_core_state (
  // clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   resetn_i,
  // data path operations from the instruction sequencer
  input  wire cslp_pkg::cslp_op_t     op_i,
  input  wire logic                   cli_i,
  input  wire logic                   sei_i,
  input  wire logic                   insn_done_i,
  // program counter
  input  wire logic                   pc_inc_i,
  input  wire logic                   pc_load_i,
  input  wire logic [15:0]            pc_target_i,
  output logic      [15:0]            pc_o,
  output logic      [cslp_pkg::ADDR_W-1:0] fetch_addr_o,
  // indexed address forming
  input  wire cslp_pkg::cslp_idx_t    idx_mode_i,
  input  wire logic [15:0]            idx_offset_i,
  output logic      [cslp_pkg::ADDR_W-1:0] idx_addr_o,
  // stack operations
  input  wire logic                   stack_reset_i,
  input  wire logic                   call_i,
  input  wire logic                   rts_i,
  input  wire logic                   rti_i,
  input  wire logic [7:0]             stack_rdata_i,
  output logic      [cslp_pkg::ADDR_W-1:0] stack_addr_o,
  output logic                        stack_wr_o,
  output logic                        stack_rd_o,
  output logic      [7:0]             stack_wdata_o,
  // low-power instructions
  input  wire logic                   stop_i,
  input  wire logic                   wait_i,
  // interrupt sources, asynchronous except tick enables
  input  wire logic                   irq_pin_n_i,
  input  wire logic                   key_wake_i,
  input  wire logic                   spi_slave_irq_i,
  input  wire logic                   tick_irq_i,
  input  wire logic                   tick_en_i,
  input  wire logic                   tick_low_freq_crystal_clock_i,
  // watchdog configuration and timeout
  input  wire logic                   wdog_en_i,
  input  wire logic                   wdog_low_freq_crystal_clock_i,
  input  wire logic                   wdog_timeout_i,
  // register views and status
  output logic      [7:0]             acc_o,
  output logic      [7:0]             idx_o,
  output logic      [cslp_pkg::ADDR_W-1:0] sp_addr_o,
  output logic      [7:0]             ccr_o,
  output logic                        busy_o,
  output logic                        vec_fetch_o,
  output logic      [cslp_pkg::NSRC-1:0] vec_src_o,
  output cslp_pkg::cslp_pwr_t         pwr_o,
  output logic                        sys_rst_req_o
);

  // ---------------------------------------------------------------- sync
  logic [4:0] async_w;
  logic [4:0] sync_w;
  logic       irq_lvl_w;
  logic       irq_lvl_q;
  logic       key_w;
  logic       spi_w;
  logic       tick_w;
  logic       wdog_to_w;

  // pin inverted so the synchroniser's reset value matches the idle-high pin
  assign async_w = {wdog_timeout_i, tick_irq_i, spi_slave_irq_i, key_wake_i, ~irq_pin_n_i};

  cslp_sync3 #(
    .W (5)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .async_i   (async_w),
    .sync_o    (sync_w)
  );

  assign irq_lvl_w = ~sync_w[0];
  assign key_w     = sync_w[1];
  assign spi_w     = sync_w[2];
  assign tick_w    = sync_w[3] & tick_en_i;
  assign wdog_to_w = sync_w[4];

  // ---------------------------------------------------------------- state
  cslp_pkg::cslp_state_t state_q;
  cslp_pkg::cslp_state_t state_d;
  cslp_pkg::cslp_seq_t   seq_q;
  cslp_pkg::cslp_seq_t   seq_d;
  logic [2:0]            cnt_q;
  logic [2:0]            cnt_d;
  logic [7:0]            acc_q;
  logic [7:0]            x_q;
  logic [15:0]           pc_q;
  logic [cslp_pkg::SP_W-1:0] sp_q;
  cslp_pkg::cslp_flags_t fl_q;
  logic                  irq_pend_q;
  logic                  mask_q;

  wire st_run     = (state_q == cslp_pkg::CSLP_RUN);
  wire st_stack   = (state_q == cslp_pkg::CSLP_STACK);
  wire st_vect    = (state_q == cslp_pkg::CSLP_VECT);
  wire st_unstack = (state_q == cslp_pkg::CSLP_UNSTACK);
  wire st_wait    = (state_q == cslp_pkg::CSLP_WAIT);
  wire st_stop    = (state_q == cslp_pkg::CSLP_STOP);

  // ---------------------------------------------------------------- interrupts
  // the pin is negative-edge triggered; the edge is latched until serviced
  wire irq_fall = irq_lvl_q & ~irq_lvl_w;

  wire [cslp_pkg::NSRC-1:0] pend_w = {irq_pend_q, key_w, spi_w, tick_w};
  wire any_pend = |pend_w;

  function automatic logic [cslp_pkg::NSRC-1:0] pick_src(
    input logic [cslp_pkg::NSRC-1:0] p
  );
    logic [cslp_pkg::NSRC-1:0] r;
    r = '0;
    if (p[cslp_pkg::SRC_IRQ]) begin
      r[cslp_pkg::SRC_IRQ] = 1'b1;
    end else if (p[cslp_pkg::SRC_KEY]) begin
      r[cslp_pkg::SRC_KEY] = 1'b1;
    end else if (p[cslp_pkg::SRC_SPI]) begin
      r[cslp_pkg::SRC_SPI] = 1'b1;
    end else if (p[cslp_pkg::SRC_TICK]) begin
      r[cslp_pkg::SRC_TICK] = 1'b1;
    end
    return r;
  endfunction

  wire [cslp_pkg::NSRC-1:0] src_w = pick_src(pend_w);

  // a masked request is only held, never dropped
  wire take_int = st_run & insn_done_i & any_pend & ~mask_q;

  // only these sources can restart the stopped oscillator
  wire stop_wake = irq_pend_q | key_w | spi_w | (tick_w & tick_low_freq_crystal_clock_i);
  // wait ends on an enabled tick or the external pin
  wire wait_wake = irq_pend_q | tick_w;

  // ---------------------------------------------------------------- alu
  wire       cin_w   = op_i.adc & fl_q.c;
  wire [4:0] lo_sum  = {1'b0, acc_q[3:0]} + {1'b0, op_i.data[3:0]} + {4'h0, cin_w};
  wire [8:0] sum_w   = {1'b0, acc_q} + {1'b0, op_i.data} + {8'h00, cin_w};
  wire [7:0] res_w   = op_i.add ? sum_w[7:0] : op_i.data;
  wire       op_ok   = st_run;

  // ---------------------------------------------------------------- addressing
  // only thirteen bits leave the core, so higher bits alias
  wire [15:0] idx_full =
      (idx_mode_i == cslp_pkg::CSLP_IDX_NONE) ? {cslp_pkg::ZERO_BYTE, x_q} :
      (idx_mode_i == cslp_pkg::CSLP_IDX_OFF8) ? {8'h00, x_q} + {8'h00, idx_offset_i[7:0]} :
                                                {8'h00, x_q} + idx_offset_i;

  wire [cslp_pkg::SP_W-1:0] sp_inc = sp_q + 6'h01;
  wire [cslp_pkg::SP_W-1:0] sp_dec = sp_q - 6'h01;

  // ---------------------------------------------------------------- stacking
  wire [2:0] seq_len = (seq_q == cslp_pkg::CSLP_SEQ_INT || seq_q == cslp_pkg::CSLP_SEQ_RTI)
                       ? cslp_pkg::INT_BYTES : cslp_pkg::CALL_BYTES;
  wire       seq_last = (cnt_q == seq_len - 3'h1);
  // pulls run in reverse slot order
  wire [2:0] pull_slot = seq_len - 3'h1 - cnt_q;
  wire [7:0] ccr_w = {cslp_pkg::CCR_ONES, fl_q.h, mask_q, fl_q.n, fl_q.z, fl_q.c};

  function automatic logic [7:0] slot_byte(
    input logic [2:0]  s,
    input logic [15:0] pc,
    input logic [7:0]  x,
    input logic [7:0]  a,
    input logic [7:0]  condition_flags_register
  );
    logic [7:0] b;
    b = 8'h00;
    case (s)
      cslp_pkg::SLOT_PCL: b = pc[7:0];
      cslp_pkg::SLOT_PCH: b = pc[15:8];
      cslp_pkg::SLOT_X:   b = x;
      cslp_pkg::SLOT_A:   b = a;
      cslp_pkg::SLOT_CCR: b = condition_flags_register;
      default:            b = 8'h00;
    endcase
    return b;
  endfunction

  wire do_push = st_stack;
  wire do_pull = st_unstack;

  // ---------------------------------------------------------------- next state
  always_comb begin
    state_d = state_q;
    seq_d   = seq_q;
    cnt_d   = cnt_q;
    case (state_q)
      cslp_pkg::CSLP_RUN: begin
        cnt_d = 3'h0;
        if (take_int) begin
          state_d = cslp_pkg::CSLP_STACK;
          seq_d   = cslp_pkg::CSLP_SEQ_INT;
        end else if (stop_i) begin
          state_d = cslp_pkg::CSLP_STOP;
        end else if (wait_i) begin
          state_d = cslp_pkg::CSLP_WAIT;
        end else if (call_i) begin
          state_d = cslp_pkg::CSLP_STACK;
          seq_d   = cslp_pkg::CSLP_SEQ_CALL;
        end else if (rti_i) begin
          state_d = cslp_pkg::CSLP_UNSTACK;
          seq_d   = cslp_pkg::CSLP_SEQ_RTI;
        end else if (rts_i) begin
          state_d = cslp_pkg::CSLP_UNSTACK;
          seq_d   = cslp_pkg::CSLP_SEQ_RTS;
        end
      end
      cslp_pkg::CSLP_STACK: begin
        cnt_d = cnt_q + 3'h1;
        if (seq_last) begin
          state_d = (seq_q == cslp_pkg::CSLP_SEQ_INT) ? cslp_pkg::CSLP_VECT
                                                      : cslp_pkg::CSLP_RUN;
        end
      end
      cslp_pkg::CSLP_UNSTACK: begin
        cnt_d = cnt_q + 3'h1;
        if (seq_last) begin
          state_d = cslp_pkg::CSLP_RUN;
        end
      end
      cslp_pkg::CSLP_VECT: begin
        state_d = cslp_pkg::CSLP_RUN;
      end
      // a waking request enters the handler straight away
      cslp_pkg::CSLP_WAIT: begin
        if (wait_wake) begin
          state_d = cslp_pkg::CSLP_STACK;
          seq_d   = cslp_pkg::CSLP_SEQ_INT;
        end
      end
      cslp_pkg::CSLP_STOP: begin
        if (stop_wake) begin
          state_d = cslp_pkg::CSLP_STACK;
          seq_d   = cslp_pkg::CSLP_SEQ_INT;
        end
      end
      default: state_d = cslp_pkg::CSLP_RUN;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q   <= cslp_pkg::CSLP_RUN;
      seq_q     <= cslp_pkg::CSLP_SEQ_CALL;
      cnt_q     <= 3'h0;
      irq_lvl_q <= 1'b1;
    end else begin
      state_q   <= state_d;
      seq_q     <= seq_d;
      cnt_q     <= cnt_d;
      irq_lvl_q <= irq_lvl_w;
    end
  end

  // new edge wins over the clear taken on entry
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_pend_q <= 1'b0;
    end else if (irq_fall) begin
      irq_pend_q <= 1'b1;
    end else if (st_vect && src_w[cslp_pkg::SRC_IRQ]) begin
      irq_pend_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------- stack pointer
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sp_q <= cslp_pkg::SP_TOP;
    end else if (op_ok && stack_reset_i) begin
      sp_q <= cslp_pkg::SP_TOP;
    end else if (do_push) begin
      sp_q <= sp_dec;   // six-bit field wraps inside the page
    end else if (do_pull) begin
      sp_q <= sp_inc;
    end
  end

  // ---------------------------------------------------------------- program counter
  // no reset here: the reset vector is loaded through pc_load_i
  always_ff @(posedge sys_clk_i) begin
    if (do_pull && pull_slot == cslp_pkg::SLOT_PCH) begin
      pc_q[15:8] <= stack_rdata_i;
    end else if (do_pull && pull_slot == cslp_pkg::SLOT_PCL) begin
      pc_q[7:0] <= stack_rdata_i;
    end else if ((op_ok || st_vect) && pc_load_i) begin
      pc_q <= pc_target_i;
    end else if (op_ok && pc_inc_i) begin
      pc_q <= pc_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------- accumulator, index
  // neither has a reset, so contents survive any device reset
  // gating with op_ok freezes them through stop and wait
  always_ff @(posedge sys_clk_i) begin
    if (do_pull && pull_slot == cslp_pkg::SLOT_A) begin
      acc_q <= stack_rdata_i;
    end else if (op_ok && op_i.acc_we) begin
      acc_q <= res_w;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (do_pull && pull_slot == cslp_pkg::SLOT_X) begin
      x_q <= stack_rdata_i;
    end else if (op_ok && op_i.x_we) begin
      x_q <= res_w;
    end
  end

  // ---------------------------------------------------------------- result flags
  // only the mask has a reset
  always_ff @(posedge sys_clk_i) begin
    fl_q.i <= mask_q;
    if (do_pull && pull_slot == cslp_pkg::SLOT_CCR) begin
      {fl_q.h, fl_q.n, fl_q.z, fl_q.c} <= {stack_rdata_i[4], stack_rdata_i[2:0]};
    end else if (op_ok) begin
      if (op_i.add) begin
        fl_q.h <= lo_sum[cslp_pkg::HC_BIT];
      end
      if (op_i.nz_we) begin
        fl_q.n <= res_w[cslp_pkg::SIGN_BIT];
        fl_q.z <= (res_w == cslp_pkg::ZERO_BYTE);
      end
      if (op_i.add) begin
        fl_q.c <= sum_w[8];
      end else if (op_i.c_we) begin
        fl_q.c <= op_i.c_val;   // inc and dec never raise c_we
      end
    end
  end

  // mask: set by reset and entry, cleared by clear, stop, wait or a return pulling it clear
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask_q <= 1'b1;
    end else if (st_stack && seq_last && seq_q == cslp_pkg::CSLP_SEQ_INT) begin
      mask_q <= 1'b1;   // after the fifth push, before the vector
    end else if (do_pull && pull_slot == cslp_pkg::SLOT_CCR) begin
      mask_q <= stack_rdata_i[3];
    end else if (op_ok && !take_int && (stop_i || wait_i || cli_i)) begin
      mask_q <= 1'b0;
    end else if (op_ok && sei_i) begin
      mask_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------- outputs
  assign acc_o        = acc_q;
  assign idx_o        = x_q;
  assign pc_o         = pc_q;
  assign fetch_addr_o = pc_q[cslp_pkg::ADDR_W-1:0];
  assign idx_addr_o   = idx_full[cslp_pkg::ADDR_W-1:0];
  assign sp_addr_o    = cslp_pkg::SP_BASE | {7'h00, sp_q};
  assign ccr_o        = ccr_w;   // upper three read as one
  assign busy_o       = ~st_run;

  assign stack_addr_o  = cslp_pkg::SP_BASE | {7'h00, (do_pull ? sp_inc : sp_q)};
  assign stack_wr_o    = do_push;
  assign stack_rd_o    = do_pull;
  assign stack_wdata_o = slot_byte(cnt_q, pc_q, x_q, acc_q, ccr_w);

  assign vec_fetch_o = st_vect;
  assign vec_src_o   = st_vect ? src_w : '0;

  // stop kills the main oscillator; wait only the cpu and bus
  assign pwr_o.osc_en        = ~st_stop;
  assign pwr_o.cpu_clk_en    = ~(st_stop | st_wait);
  assign pwr_o.bus_en        = ~(st_stop | st_wait);
  assign pwr_o.timer_clk_en  = ~st_stop | tick_low_freq_crystal_clock_i;
  // a watchdog on the main oscillator cannot count through stop
  assign pwr_o.wdog_count_en = wdog_en_i & (~st_stop | wdog_low_freq_crystal_clock_i);
  assign sys_rst_req_o       = wdog_en_i & wdog_to_w;

endmodule

// File: tb/cslp_core_state_properties.sv
// concurrent checks on the ports of the processor state and low-power block
`timescale 1ns/1ps
module cslp_core_state_properties (
  // clock and reset
  input wire logic                     sys_clk_i,
  input wire logic                     resetn_i,
  // requests
  input wire logic                     insn_done_i,
  input wire logic                     cli_i,
  input wire logic                     stop_i,
  input wire logic                     wait_i,
  input wire logic                     rti_i,
  input wire logic                     call_i,
  input wire logic                     pc_inc_i,
  input wire logic                     pc_load_i,
  input wire logic [15:0]              pc_target_i,
  input wire cslp_pkg::cslp_idx_t      idx_mode_i,
  input wire logic                     tick_low_freq_crystal_clock_i,
  input wire logic                     wdog_en_i,
  // observed outputs
  input wire logic [15:0]              pc_o,
  input wire logic [12:0]              fetch_addr_o,
  input wire logic [12:0]              idx_addr_o,
  input wire logic [7:0]               idx_o,
  input wire logic [12:0]              sp_addr_o,
  input wire logic [7:0]               ccr_o,
  input wire logic                     busy_o,
  input wire logic                     stack_wr_o,
  input wire logic                     vec_fetch_o,
  input wire logic [3:0]               vec_src_o,
  input wire cslp_pkg::cslp_pwr_t      pwr_o,
  input wire logic                     sys_rst_req_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  AST_CCR_ONES: assert property (ccr_o[7:5] == 3'h7)
    else $error("upper flag bits not all one");
  AST_FETCH_MIRROR: assert property (fetch_addr_o == pc_o[12:0])
    else $error("fetch address not low pc bits");
  AST_SP_PAGE: assert property (sp_addr_o[12:6] == 7'h03)
    else $error("stack address left its page");
  AST_IDX_NONE: assert property (idx_mode_i == cslp_pkg::CSLP_IDX_NONE |->
    idx_addr_o == {5'h00, idx_o}) else $error("plain indexed address wrong");
  // stop and wait are excluded at an instruction boundary, where an interrupt may win
  AST_STOP_ENTRY: assert property (stop_i && !busy_o && !insn_done_i |=>
    !ccr_o[3] && !pwr_o.osc_en && pwr_o.timer_clk_en == tick_low_freq_crystal_clock_i)
    else $error("stop entry wrong");
  AST_WAIT_ENTRY: assert property (wait_i && !stop_i && !busy_o && !insn_done_i |=>
    !ccr_o[3] && !pwr_o.cpu_clk_en && !pwr_o.bus_en && pwr_o.timer_clk_en)
    else $error("wait entry wrong");
  AST_CALL_PUSH: assert property (call_i && !stop_i && !wait_i && !busy_o && !insn_done_i
    |=> stack_wr_o [*2] ##1 !busy_o) else $error("call did not push two bytes");
  AST_VEC_MASK: assert property (vec_fetch_o |-> ccr_o[3] && $onehot(vec_src_o))
    else $error("vector fetched with mask clear");
  AST_PC_LOAD: assert property (pc_load_i && !busy_o && !insn_done_i |=>
    pc_o == $past(pc_target_i)) else $error("pc load wrong");
  AST_PC_INC: assert property (pc_inc_i && !pc_load_i && !busy_o && !insn_done_i |=>
    pc_o == $past(pc_o) + 16'h0001) else $error("pc increment wrong");
  AST_WDOG_REQ: assert property (sys_rst_req_o |-> wdog_en_i)
    else $error("reset request from disabled watchdog");
  AST_MASK_CLEAR: assert property ($fell(ccr_o[3]) |->
    $past(cli_i || stop_i || wait_i || rti_i || busy_o)) else $error("mask cleared without cause");

  COV_VEC: cover property (vec_fetch_o);
  COV_STOP: cover property (!pwr_o.osc_en);
  COV_CALL: cover property (stack_wr_o ##1 stack_wr_o);
endmodule

// File: tb/testbench.sv
// self-checking bench for the processor state and low-power block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("FAIL t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  localparam int MASK_CLEAR_INSTR = 0, INSN = 1, PCINC = 2, PCLD = 3, SPRST = 4;
  localparam int CALL = 5, RTS = 6, RETURN_FROM_HANDLER_INSTR = 7, STOP = 8, WAIT = 9;
  logic                sys_clk_i = 1'b0;
  logic                resetn_i = 1'b0;
  cslp_pkg::cslp_op_t  op_i = '0;
  logic [9:0]          pl = '0;
  wire logic           cli_i, insn_done_i, pc_inc_i, pc_load_i, stack_reset_i;
  wire logic           call_i, rts_i, rti_i, stop_i, wait_i;
  logic                sei_i = 1'b0;
  logic [15:0]         pc_target_i = 16'hE123;
  cslp_pkg::cslp_idx_t idx_mode_i = cslp_pkg::CSLP_IDX_NONE;
  logic [15:0]         idx_offset_i = 16'h0000;
  logic [7:0]          stack_rdata_i = 8'h00;
  logic                irq_pin_n_i = 1'b1, key_wake_i = 1'b0, spi_slave_irq_i = 1'b0;
  logic                tick_irq_i = 1'b0, tick_en_i = 1'b0, tick_low_freq_crystal_clock_i = 1'b0;
  logic                wdog_en_i = 1'b0, wdog_low_freq_crystal_clock_i = 1'b0, wdog_timeout_i = 1'b0;
  logic [15:0]         pc_o;
  logic [12:0]         fetch_addr_o, idx_addr_o, stack_addr_o, sp_addr_o;
  logic                stack_wr_o, stack_rd_o, busy_o, vec_fetch_o, sys_rst_req_o;
  logic [7:0]          stack_wdata_o, acc_o, idx_o, ccr_o;
  logic [3:0]          vec_src_o;
  cslp_pkg::cslp_pwr_t pwr_o;
  int                  n_fail = 0, n_compared = 0, n_wr = 0, n_cyc = 0;
  logic [20:0]         last_wr = '0;

  assign {wait_i, stop_i, rti_i, rts_i, call_i, stack_reset_i, pc_load_i, pc_inc_i,
          insn_done_i, cli_i} = pl;

  cslp_core_state dut (.sys_clk_i, .resetn_i, .op_i, .cli_i, .sei_i, .insn_done_i, .pc_inc_i,
    .pc_load_i, .pc_target_i, .pc_o, .fetch_addr_o, .idx_mode_i, .idx_offset_i, .idx_addr_o,
    .stack_reset_i, .call_i, .rts_i, .rti_i, .stack_rdata_i, .stack_addr_o, .stack_wr_o,
    .stack_rd_o, .stack_wdata_o, .stop_i, .wait_i, .irq_pin_n_i, .key_wake_i, .spi_slave_irq_i,
    .tick_irq_i, .tick_en_i, .tick_low_freq_crystal_clock_i, .wdog_en_i, .wdog_low_freq_crystal_clock_i, .wdog_timeout_i, .acc_o,
    .idx_o, .sp_addr_o, .ccr_o, .busy_o, .vec_fetch_o, .vec_src_o, .pwr_o, .sys_rst_req_o);

  always #2 sys_clk_i = ~sys_clk_i;

  // run is a few hundred cycles at most, so the ceiling only trips on a hang
  always @(posedge sys_clk_i) begin
    n_cyc++;
    if (stack_wr_o === 1'b1) begin
      n_wr++;
      last_wr = {stack_addr_o, stack_wdata_o};
    end
    if (n_cyc == 6000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out;
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask

  task automatic rst;
    @(posedge sys_clk_i) resetn_i <= 1'b0;
    cyc(5);
    @(posedge sys_clk_i) resetn_i <= 1'b1;
    @(negedge sys_clk_i);
  endtask

  task automatic pulse(input int b);
    @(posedge sys_clk_i) pl <= 10'h001 << b;
    @(posedge sys_clk_i) pl <= '0;
    @(negedge sys_clk_i);
  endtask

  task automatic do_op(input logic [7:0] d, input logic ad, input logic aw, input logic xw);
    @(posedge sys_clk_i) op_i <= '{acc_we: aw, x_we: xw, nz_we: 1'b1, c_we: 1'b0,
                                   c_val: 1'b0, add: ad, adc: 1'b0, data: d};
    @(posedge sys_clk_i) op_i <= '0;
    @(negedge sys_clk_i);
  endtask

  // vec selects the wait for a vector cycle, otherwise for the core going idle
  task automatic wait_on(input bit vec);
    int k;
    k = 0;
    do begin
      @(negedge sys_clk_i);
      k++;
    end while (k < 40 && (vec ? vec_fetch_o !== 1'b1 : busy_o !== 1'b0));
    `CHK(k < 40, 1'b1)
  endtask

  task automatic chk_idx(input cslp_pkg::cslp_idx_t m, input logic [15:0] o,
                         input logic [12:0] e);
    @(posedge sys_clk_i) idx_mode_i <= m;
    idx_offset_i <= o;
    @(negedge sys_clk_i);
    `CHK(idx_addr_o, e)
  endtask

  initial begin
    rst();
    `CHK(sp_addr_o, 13'h00FF)
    `CHK({ccr_o[7:5], ccr_o[3]}, 4'hF)
    do_op(8'h10, 1'b0, 1'b0, 1'b1);
    do_op(8'h0F, 1'b0, 1'b1, 1'b0);
    do_op(8'h01, 1'b1, 1'b1, 1'b0);
    `CHK(ccr_o, 8'hF8)
    do_op(8'h80, 1'b1, 1'b1, 1'b0);
    `CHK(ccr_o, 8'hEC)
    rst();
    `CHK({acc_o, idx_o, ccr_o[3]}, 17'h0_9010 << 1 | 17'h0_0001)
    do_op(8'h70, 1'b1, 1'b1, 1'b0);
    `CHK({acc_o, ccr_o}, 16'h00EB)
    chk_idx(cslp_pkg::CSLP_IDX_NONE, 16'h1FF0, 13'h0010);
    chk_idx(cslp_pkg::CSLP_IDX_OFF8, 16'h00F5, 13'h0105);
    chk_idx(cslp_pkg::CSLP_IDX_OFF16, 16'hFFF0, 13'h0000);
    pulse(PCLD);
    `CHK({pc_o, fetch_addr_o}, {16'hE123, 13'h0123})
    pulse(PCINC);
    `CHK(pc_o, 16'hE124)
    pulse(CALL);
    wait_on(1'b0);
    `CHK({last_wr, sp_addr_o}, {13'h00FE, 8'hE1, 13'h00FD})
    pulse(RTS);
    wait_on(1'b0);
    `CHK(sp_addr_o, 13'h00FF)
    repeat (32) begin
      pulse(CALL);
      wait_on(1'b0);
    end
    `CHK({n_wr[7:0], sp_addr_o}, {8'h42, 13'h00FF})
    @(posedge sys_clk_i) tick_irq_i <= 1'b1;
    tick_en_i <= 1'b1;
    wdog_en_i <= 1'b1;
    pulse(STOP);
    `CHK({ccr_o[3], pwr_o.osc_en, acc_o}, 10'h000)
    cyc(12);
    `CHK({busy_o, pwr_o.timer_clk_en, pwr_o.wdog_count_en}, 3'b100)
    @(posedge sys_clk_i) key_wake_i <= 1'b1;
    wait_on(1'b1);
    `CHK({vec_src_o, ccr_o[3]}, 5'h09)
    @(posedge sys_clk_i) key_wake_i <= 1'b0;
    tick_en_i <= 1'b0;
    wait_on(1'b0);
    `CHK(sp_addr_o, 13'h00FA)
    pulse(WAIT);
    `CHK({ccr_o[3], pwr_o.cpu_clk_en, pwr_o.bus_en, pwr_o.timer_clk_en}, 4'h1)
    cyc(12);
    `CHK(busy_o, 1'b1)
    @(posedge sys_clk_i) irq_pin_n_i <= 1'b0;
    wait_on(1'b1);
    `CHK(vec_src_o, 4'h8)
    @(posedge sys_clk_i) tick_irq_i <= 1'b0;
    irq_pin_n_i <= 1'b1;
    cyc(8);
    @(posedge sys_clk_i) irq_pin_n_i <= 1'b0;
    cyc(8);
    pulse(INSN);
    cyc(3);
    `CHK(busy_o, 1'b0)
    @(posedge sys_clk_i) stack_rdata_i <= 8'hE0;
    pulse(RETURN_FROM_HANDLER_INSTR);
    wait_on(1'b0);
    `CHK({ccr_o[3], acc_o}, 9'h0E0)
    pulse(INSN);
    wait_on(1'b1);
    `CHK(vec_src_o, 4'h8)
    @(posedge sys_clk_i) wdog_timeout_i <= 1'b1;
    cyc(8);
    `CHK(sys_rst_req_o, 1'b1)
    @(posedge sys_clk_i) wdog_en_i <= 1'b0;
    @(negedge sys_clk_i);
    `CHK(sys_rst_req_o, 1'b0)
    close_out();
  end
endmodule

bind cslp_core_state cslp_core_state_properties u_props (.sys_clk_i, .resetn_i, .insn_done_i,
  .cli_i, .stop_i, .wait_i, .rti_i, .call_i, .pc_inc_i, .pc_load_i, .pc_target_i, .idx_mode_i,
  .tick_low_freq_crystal_clock_i, .wdog_en_i, .pc_o, .fetch_addr_o, .idx_addr_o, .idx_o, .sp_addr_o, .ccr_o,
  .busy_o, .stack_wr_o, .vec_fetch_o, .vec_src_o, .pwr_o, .sys_rst_req_o);
